// ---- fifo_dma_consts.vh ----
// What this block does
// (R1) Write: request while FIFO has free space
// (R2) Read: request only with data and enabled
// (R3) Acknowledge alone marks transfer, chip select ignored
// (R4) Acknowledge plus low chip select marks transfer
// (R5) Data port register accesses count as transfers
// (R6) Software sets channel activate before use
// (R7) Count mode requests only while count nonzero
// (R8) Burst option: readiness at least burst quantity
// (R9) Burst, small remainder: readiness reaches remaining count
// (R10) Free-run burst: readiness at least quantity
// (R11) Word transfers; single byte only last count
// (R12) Count mode plain: readiness two, or count
// (R13) Free-run plain: request while readiness two
// (R14) Request and acknowledge polarity selectable
// (R15) Load counter, go; one byte needs count one
// (R16) Running reads one from go until halt
// (R17) Count operation ends on exhaustion or stop
// (R18) Completion flag set when operation stops
// (R19) Request drops during final counted strobe
// (R20) Stop halts channel and drops request
// (R21) Software clears FIFO after odd write
// (R22) Request follows readiness while channel runs
// (R23) Two identical independent channels
`ifndef FIFO_DMA_CONSTS_VH
`define FIFO_DMA_CONSTS_VH
`define CHANNELS     2
`define COUNT_W      32
`define READY_W      16
`define BURST_W      2
`define SYNC_W       4
`define WORD_BYTES   16'h0002
`define ONE_BYTE     16'h0001
`define READY_NONE   16'h0000
`define READY_PAD    16'h0000
`define BURST_Q0     16'h0004
`define BURST_Q1     16'h0008
`define BURST_Q2     16'h0010
`define BURST_Q3     16'h0020
`define COUNT_ZERO   32'h0000_0000
`define COUNT_ONE    32'h0000_0001
`define SYNC_IDLE    4'hf
`endif

// ---- pin_sync.v ----
`timescale 1ns/1ps
`include "fifo_dma_consts.vh"
module pin_sync #(
  parameter W = `SYNC_W
) (
  // Clock and reset
  input  wire         clk,
  input  wire         srst,
  // Asynchronous pins and their synchronised copies
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] pin_sync_out
);

  reg [W-1:0] stage1;

  // Idle level is all ones: the pins are active low by default
  always @(posedge clk)
  begin
    if (srst)
    begin
      stage1       <= `SYNC_IDLE;
      pin_sync_out <= `SYNC_IDLE;
    end
    else
    begin
      stage1       <= pin_in;
      pin_sync_out <= stage1;
    end
  end

endmodule // pin_sync

// ---- request_eval.v ----
`timescale 1ns/1ps
`include "fifo_dma_consts.vh"
module request_eval (
  // Mode
  input  wire                 count_mode,
  input  wire                 burst_enable,
  input  wire [`BURST_W-1:0]  burst_threshold,
  // Counter and FIFO readiness in bytes
  input  wire [`COUNT_W-1:0]  count,
  input  wire [`READY_W-1:0]  ready,
  // Decision
  output reg                  assert_req,
  output reg  [`READY_W-1:0]  grant_len
);

  reg [`READY_W-1:0] qty;
  reg [`COUNT_W-1:0] ready_x;
  reg [`COUNT_W-1:0] qty_x;

  always @*
  begin
    case (burst_threshold)
      2'h0:    qty = `BURST_Q0;
      2'h1:    qty = `BURST_Q1;
      2'h2:    qty = `BURST_Q2;
      default: qty = `BURST_Q3;
    endcase
    ready_x    = {`READY_PAD, ready};
    qty_x      = {`READY_PAD, qty};
    assert_req = 1'b0;
    grant_len  = qty;
    if (count_mode)
    begin
      if (count == `COUNT_ZERO)
        assert_req = 1'b0;                                   // [R7]
      else if (burst_enable)
      begin
        if (count >= qty_x)
          assert_req = (ready >= qty);                       // [R8]
        else
        begin
          assert_req = (ready_x >= count);                   // [R9]
          grant_len  = count[`READY_W-1:0];
        end
      end
      else if (count >= ready_x)
      begin
        // A lone free byte is usable only for the last count
        assert_req = (ready >= `WORD_BYTES) ||
                     ((count == `COUNT_ONE) && (ready == `ONE_BYTE)); // [R12] [R15] [R11]
        grant_len  = ready;
      end
      else
      begin
        assert_req = 1'b1;                                   // [R12]
        grant_len  = count[`READY_W-1:0];
      end
    end
    else if (burst_enable)
      assert_req = (ready >= qty);                           // [R10] [R8]
    else
    begin
      assert_req = (ready >= `WORD_BYTES);                   // [R13]
      grant_len  = ready;
    end
  end

endmodule // request_eval

// ---- fifo_dma_request_port.v ----
`timescale 1ns/1ps
`include "fifo_dma_consts.vh"
module fifo_dma_request_port (
  // Clock and reset
  input  wire                               clk,
  input  wire                               srst,
  // Chip setup
  input  wire                               cs_mode,
  input  wire [`CHANNELS-1:0]               req_polarity,
  input  wire [`CHANNELS-1:0]               acknowledge_polarity,
  // Channel setup
  input  wire [`CHANNELS-1:0]               channel_activate,
  input  wire [`CHANNELS-1:0]               access_by_register,
  input  wire [`CHANNELS-1:0]               free_run,
  input  wire [`CHANNELS-1:0]               burst_enable,
  input  wire [`CHANNELS*`BURST_W-1:0]      burst_threshold,
  input  wire [`CHANNELS-1:0]               read_direction,
  // Channel control pulses
  input  wire [`CHANNELS-1:0]               go,
  input  wire [`CHANNELS-1:0]               stop,
  input  wire [`CHANNELS-1:0]               count_load,
  input  wire [`CHANNELS*`COUNT_W-1:0]      count_value,
  input  wire [`CHANNELS-1:0]               complete_clear,
  input  wire [`CHANNELS-1:0]               overflow_clear,
  // FIFO side
  input  wire [`CHANNELS*`READY_W-1:0]      fifo_ready,
  input  wire [`CHANNELS-1:0]               read_enable,
  // Register decode of the channel data port
  input  wire [`CHANNELS-1:0]               data_port_access,
  // External bus pins
  input  wire [`CHANNELS-1:0]               dma_acknowledge_n,
  input  wire                               chip_select_n,
  input  wire                               access_strobe_n,
  output wire [`CHANNELS-1:0]               dma_request_n,
  // Status
  output wire [`CHANNELS-1:0]               running,
  output wire [`CHANNELS*`COUNT_W-1:0]      transfer_counter,
  output wire [`CHANNELS-1:0]               complete_flag,
  output wire [`CHANNELS-1:0]               count_overflow,
  // Transfer indication toward the FIFO
  output wire [`CHANNELS-1:0]               transfer_taken,
  output wire [`CHANNELS-1:0]               transfer_byte
);

  wire [`SYNC_W-1:0] pins_s;
  wire               strobe_s;
  wire               cs_s;
  wire [1:0]         ack_s;
  reg                strobe_prev;
  wire               strobe_start;

  pin_sync #(
    .W (`SYNC_W)
  ) u_pin_sync (
    .clk          (clk),
    .srst         (srst),
    .pin_in       ({access_strobe_n, chip_select_n, dma_acknowledge_n}),
    .pin_sync_out (pins_s)
  );

  assign strobe_s = pins_s[3];
  assign cs_s     = pins_s[2];
  assign ack_s    = pins_s[1:0];

  // Count on the leading edge so the last strobe can still drop the request
  always @(posedge clk)
  begin
    if (srst)
      strobe_prev <= 1'b0;
    else
      strobe_prev <= ~strobe_s;
  end

  assign strobe_start = ~strobe_s & ~strobe_prev;

  genvar c;
  generate
    for (c = 0; c < `CHANNELS; c = c + 1)
    begin : g_chan                                           // [R23]
      reg                 run;
      reg                 req_on;
      reg                 done;
      reg                 ovf;
      reg                 taken;
      reg                 byte_x;
      reg [`COUNT_W-1:0]  count;
      reg [`READY_W-1:0]  burst_left;
      wire                eval_assert;
      wire [`READY_W-1:0] eval_len;
      wire                count_mode;
      wire                ack_active;
      wire                pin_hit;
      wire                hit;
      wire                size_byte;
      wire [`READY_W-1:0] size;
      wire [`COUNT_W-1:0] size_x;
      wire [`COUNT_W:0]   count_up;
      wire                last;
      wire                ready_ok;

      request_eval u_request_eval (
        .count_mode      (count_mode),
        .burst_enable    (burst_enable[c]),
        .burst_threshold (burst_threshold[c*`BURST_W +: `BURST_W]),
        .count           (count),
        .ready           (fifo_ready[c*`READY_W +: `READY_W]),
        .assert_req      (eval_assert),
        .grant_len       (eval_len)
      );

      assign count_mode = ~free_run[c];
      // Acknowledge is active when the pin equals the configured active level
      assign ack_active = (ack_s[c] == acknowledge_polarity[c]);         // [R14]
      assign pin_hit    = strobe_start & ack_active & (~cs_mode | ~cs_s); // [R3] [R4]
      // Activation is required here, so a mis-set channel ignores strobes and data port accesses yet still asserts its request
      assign hit        = channel_activate[c] & run &
                          (access_by_register[c] ? data_port_access[c] : pin_hit); // [R5] [R6]
      assign size_byte  = count_mode & (count == `COUNT_ONE);            // [R11]
      assign size       = size_byte ? `ONE_BYTE : `WORD_BYTES;
      assign size_x     = {`READY_PAD, size};
      assign count_up   = {1'b0, count} + {1'b0, size_x};
      assign last       = count_mode & hit & (count <= size_x);
      assign ready_ok   = eval_assert & (~read_direction[c] | read_enable[c]); // [R1] [R2]

      always @(posedge clk)
      begin
        if (srst)
        begin
          run        <= 1'b0;
          req_on     <= 1'b0;
          done       <= 1'b0;
          ovf        <= 1'b0;
          taken      <= 1'b0;
          byte_x     <= 1'b0;
          count      <= `COUNT_ZERO;
          burst_left <= `READY_NONE;
        end
        else
        begin
          taken  <= hit;
          byte_x <= hit & size_byte;

          if (count_load[c])
            count <= count_value[c*`COUNT_W +: `COUNT_W];                // [R15]
          else if (hit && count_mode)
            count <= count - size_x;
          else if (hit)
            count <= count_up[`COUNT_W-1:0];

          if (stop[c] || last)
            run <= 1'b0;                                                 // [R17] [R20]
          else if (go[c])
            run <= 1'b1;                                                 // [R16]

          // Set wins over a clear in the same cycle
          if ((stop[c] && run) || last)
            done <= 1'b1;                                                // [R18]
          else if (complete_clear[c])
            done <= 1'b0;

          if (hit && !count_mode && count_up[`COUNT_W])
            ovf <= 1'b1;
          else if (overflow_clear[c])
            ovf <= 1'b0;

          // Losing read permission also ends a granted burst
          if (stop[c] || !run || last || (read_direction[c] && !read_enable[c]))
            req_on <= 1'b0;                                              // [R19] [R20] [R2]
          else if (burst_enable[c])
          begin
            // A granted burst holds until its guaranteed length is moved,
            // then drops for at least one cycle before the next decision
            if (req_on)
            begin
              if (hit && (burst_left <= size))
                req_on <= 1'b0;                                          // [R8]
              else if (hit)
                burst_left <= burst_left - size;
            end
            else if (ready_ok)
            begin
              req_on     <= 1'b1;                                        // [R8] [R9] [R10]
              burst_left <= eval_len;
            end
          end
          else
            req_on <= ready_ok;                                          // [R22] [R7]
        end
      end

      assign dma_request_n[c] = req_on ? req_polarity[c] : ~req_polarity[c]; // [R14]
      assign running[c]       = run;
      assign complete_flag[c] = done;
      assign count_overflow[c] = ovf;
      assign transfer_taken[c] = taken;
      assign transfer_byte[c]  = byte_x;
      assign transfer_counter[c*`COUNT_W +: `COUNT_W] = count;
    end
  endgenerate

endmodule // fifo_dma_request_port

// ---- fifo_dma_request_port_sva.sv ----
`timescale 1ns/1ps
`include "fifo_dma_consts.vh"
module fifo_dma_request_port_sva (
  // Clock, reset and setup
  input wire                          clk,
  input wire                          srst,
  input wire [`CHANNELS-1:0]          req_polarity,
  input wire [`CHANNELS-1:0]          free_run,
  input wire [`CHANNELS-1:0]          burst_enable,
  input wire [`CHANNELS-1:0]          read_direction,
  input wire [`CHANNELS-1:0]          read_enable,
  input wire [`CHANNELS-1:0]          go,
  input wire [`CHANNELS-1:0]          stop,
  input wire [`CHANNELS*`READY_W-1:0] fifo_ready,
  // Status
  input wire [`CHANNELS-1:0]          dma_request_n,
  input wire [`CHANNELS-1:0]          running,
  input wire [`CHANNELS*`COUNT_W-1:0] transfer_counter,
  input wire [`CHANNELS-1:0]          complete_flag,
  input wire [`CHANNELS-1:0]          transfer_taken,
  input wire [`CHANNELS-1:0]          transfer_byte
);
  // Channel 1 is a copy, so only channel 0 is watched
  wire        act = dma_request_n[0] == req_polarity[0];
  wire [31:0] cnt = transfer_counter[31:0];
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  go_runs_a: assert property (go[0] && !stop[0] && (free_run[0] || cnt != 0) |=> running[0])
    else $error("go did not start the channel");
  stop_halts_a: assert property (stop[0] |=> !running[0])
    else $error("stop did not halt the channel");
  idle_quiet_a: assert property (!running[0] |=> !act)
    else $error("request while halted");
  zero_count_a: assert property (!free_run[0] && cnt == 0 |=> !act)
    else $error("request with empty count");
  plain_free_a: assert property (free_run[0] && !burst_enable[0] && fifo_ready[15:0] < 16'h0002 |=> !act)
    else $error("free-run request below two bytes");
  read_gate_a: assert property (read_direction[0] && !read_enable[0] |=> !act)
    else $error("read request while reading disabled");
  byte_last_a: assert property (transfer_byte[0] |-> transfer_taken[0] && cnt == 0 && !free_run[0])
    else $error("byte transfer not on last count");
  step_size_a: assert property (transfer_taken[0] && !free_run[0] |-> $past(cnt) - cnt == (transfer_byte[0] ? 1 : 2))
    else $error("counter step wrong");
  exhaust_a: assert property (transfer_taken[0] && !free_run[0] && cnt == 0 |-> !running[0] && !act)
    else $error("request after last count");
  complete_a: assert property ($fell(running[0]) |-> complete_flag[0])
    else $error("no completion flag on halt");
endmodule // fifo_dma_request_port_sva
bind fifo_dma_request_port fifo_dma_request_port_sva chk_u (.clk, .srst, .req_polarity, .free_run, .burst_enable,
  .read_direction, .read_enable, .go, .stop, .fifo_ready, .dma_request_n, .running, .transfer_counter,
  .complete_flag, .transfer_taken, .transfer_byte);

// ---- dma_master_model.sv ----
`timescale 1ns/1ps
module dma_master_model (
  // Clock and master controls
  input  wire clk,
  input  wire enable,
  input  wire ack_level,
  input  wire cs_low,
  input  wire req_active,
  // Bus pins toward the device
  output wire ack_pin,
  output wire cs_n,
  output wire strobe_n
);
  reg  [2:0] phase = 3'h0;
  wire       strobing = (phase != 3'h0) && (phase < 3'h6);
  // New strobe only from idle, so the high phase lasts at least three clocks
  always @(posedge clk)
  begin
    if (phase != 3'h0)
      phase <= phase + 3'h1;
    else if (enable && req_active)
      phase <= 3'h1;
  end
  assign strobe_n = !strobing;
  assign ack_pin  = strobing ? ack_level : !ack_level;
  assign cs_n     = !(strobing && cs_low);
endmodule // dma_master_model

// ---- fifo_dma_request_port_tb_top.sv ----
`timescale 1ns/1ps
module fifo_dma_request_port_tb_top;
  reg         clk, srst, cs_mode, m_en, m_lvl, m_cs;
  reg  [1:0]  req_polarity, acknowledge_polarity, channel_activate, access_by_register, free_run;
  reg  [1:0]  burst_enable, read_direction, go, stop, count_load, complete_clear, overflow_clear;
  reg  [1:0]  read_enable, data_port_access;
  reg  [3:0]  burst_threshold;
  reg  [63:0] count_value;
  reg  [31:0] fifo_ready;
  wire [1:0]  dma_request_n, running, complete_flag, count_overflow, transfer_taken, transfer_byte;
  wire [63:0] transfer_counter;
  wire        ack_pin, cs_pin, strobe_pin;
  integer     miscompares, n_tests, cycles;
  fifo_dma_request_port dut_u (.clk, .srst, .cs_mode, .req_polarity, .acknowledge_polarity, .channel_activate,
    .access_by_register, .free_run, .burst_enable, .burst_threshold, .read_direction, .go, .stop, .count_load,
    .count_value, .complete_clear, .overflow_clear, .fifo_ready, .read_enable, .data_port_access,
    .dma_acknowledge_n({1'b1, ack_pin}), .chip_select_n(cs_pin), .access_strobe_n(strobe_pin), .dma_request_n,
    .running, .transfer_counter, .complete_flag, .count_overflow, .transfer_taken, .transfer_byte);
  dma_master_model model_u (.clk, .enable(m_en), .ack_level(m_lvl), .cs_low(m_cs),
    .req_active(dma_request_n[0] == req_polarity[0]), .ack_pin, .cs_n(cs_pin), .strobe_n(strobe_pin));
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
        miscompares = miscompares + 1;
        $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task finish_test;
    begin
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task start(input logic [31:0] n);
    begin
      @(negedge clk);
      count_load[0] = 1'b1;
      count_value[31:0] = n;
      @(negedge clk);
      count_load[0] = 1'b0;
      go[0] = 1'b1;
      @(negedge clk);
      go[0] = 1'b0;
    end
  endtask
  task halt;
    begin
      stop[0] = 1'b1;
      @(negedge clk);
      stop[0] = 1'b0;
      repeat (2) @(negedge clk);
      check(running[0], 0, "running");
      check(dma_request_n[0], !req_polarity[0], "request");
    end
  endtask
  task eval_case(input logic f, b, input logic [1:0] t, input logic [31:0] n, input logic [15:0] r, input logic e);
    begin
      free_run[0] = f;
      burst_enable[0] = b;
      burst_threshold[1:0] = t;
      fifo_ready[15:0] = r;
      start(n);
      repeat (4) @(negedge clk);
      check(dma_request_n[0], e == req_polarity[0], "request");
      check(running[0], 1, "running");
      halt;
    end
  endtask
  task xfer(input logic [31:0] n, input logic csm, cl, lvl, input logic [31:0] words, bytes);
    integer taken, single;
    begin
      taken = 0;
      single = 0;
      cs_mode = csm;
      m_cs = cl;
      m_lvl = lvl;
      acknowledge_polarity[0] = lvl;
      free_run[0] = 1'b0;
      burst_enable[0] = 1'b0;
      // Fresh FIFO each run, as after a clear that follows an odd write
      fifo_ready[15:0] = 16'h0006;
      complete_clear[0] = 1'b1;
      @(negedge clk);
      complete_clear[0] = 1'b0;
      start(n);
      m_en = 1'b1;
      repeat (150)
      begin
        @(negedge clk);
        taken = taken + transfer_taken[0];
        single = single + transfer_byte[0];
      end
      m_en = 1'b0;
      repeat (8) @(negedge clk);
      check(taken - single, words, "words");
      check(single, bytes, "bytes");
      check(transfer_counter[31:0], n - 2 * words - bytes, "counter");
      check(complete_flag[0], n == 2 * words + bytes, "complete");
      if (running[0])
        halt;
      complete_clear[0] = 1'b1;
      @(negedge clk);
      complete_clear[0] = 1'b0;
      @(negedge clk);
      check(complete_flag[0], 0, "complete clear");
    end
  endtask
  task reg_port;
    begin
      access_by_register[1] = 1'b1;
      fifo_ready[31:16] = 16'h0006;
      count_load[1] = 1'b1;
      count_value[63:32] = 32'h0000_0004;
      @(negedge clk);
      count_load[1] = 1'b0;
      go[1] = 1'b1;
      @(negedge clk);
      go[1] = 1'b0;
      repeat (2)
      begin
        @(negedge clk);
        check(dma_request_n[1], 0, "ch1 request on");
        data_port_access[1] = 1'b1;
        @(negedge clk);
        data_port_access[1] = 1'b0;
      end
      repeat (2) @(negedge clk);
      check(transfer_counter[63:32], 0, "ch1 counter");
      check(complete_flag[1], 1, "ch1 complete");
      check(dma_request_n[1], 1, "ch1 request off");
      free_run[1] = 1'b1;
      count_load[1] = 1'b1;
      count_value[63:32] = 32'hffff_fffe;
      @(negedge clk);
      count_load[1] = 1'b0;
      go[1] = 1'b1;
      @(negedge clk);
      go[1] = 1'b0;
      @(negedge clk);
      check(dma_request_n[1], 0, "ch1 free request");
      data_port_access[1] = 1'b1;
      @(negedge clk);
      data_port_access[1] = 1'b0;
      @(negedge clk);
      check(count_overflow[1], 1, "ch1 overflow");
      check(transfer_counter[63:32], 0, "ch1 wrapped counter");
      overflow_clear[1] = 1'b1;
      @(negedge clk);
      overflow_clear[1] = 1'b0;
      check(count_overflow[1], 0, "ch1 overflow clear");
      stop[1] = 1'b1;
      @(negedge clk);
      stop[1] = 1'b0;
      @(negedge clk);
      check(running[1], 0, "ch1 stopped");
      check(dma_request_n[1], 1, "ch1 stop request");
    end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      miscompares = miscompares + 1;
      finish_test;
    end
  end
  initial
  begin
    {srst, cs_mode, m_en, m_lvl, m_cs} = 5'h10;
    {req_polarity, acknowledge_polarity, access_by_register, free_run, burst_enable} = 10'h000;
    {read_direction, go, stop, count_load, complete_clear, overflow_clear} = 12'h000;
    {read_enable, data_port_access, burst_threshold, count_value, fifo_ready} = 104'h0;
    channel_activate = 2'b11;
    {miscompares, n_tests, cycles} = 96'h0;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    check(dma_request_n, 2'b11, "reset request");
    check({running, complete_flag, count_overflow, transfer_taken, transfer_byte}, 0, "reset status");
    check(transfer_counter[31:0], 0, "reset ch0 counter");
    check(transfer_counter[63:32], 0, "reset ch1 counter");
    repeat (3) @(negedge clk);
    eval_case(0, 0, 0, 8, 6, 1);
    eval_case(0, 0, 0, 8, 1, 0);
    eval_case(0, 0, 0, 1, 1, 1);
    eval_case(0, 0, 0, 0, 6, 0);
    eval_case(0, 0, 0, 2, 6, 1);
    eval_case(1, 0, 0, 0, 1, 0);
    eval_case(1, 0, 0, 0, 2, 1);
    eval_case(0, 1, 0, 8, 3, 0);
    eval_case(0, 1, 0, 8, 4, 1);
    eval_case(0, 1, 0, 2, 2, 1);
    eval_case(0, 1, 0, 3, 2, 0);
    eval_case(1, 1, 1, 0, 7, 0);
    eval_case(1, 1, 1, 0, 8, 1);
    eval_case(1, 1, 2, 0, 16, 1);
    eval_case(1, 1, 3, 0, 31, 0);
    read_direction[0] = 1'b1;
    eval_case(0, 0, 0, 8, 6, 0);
    read_enable[0] = 1'b1;
    req_polarity[0] = 1'b1;
    eval_case(0, 0, 0, 8, 6, 1);
    read_direction[0] = 1'b0;
    req_polarity[0] = 1'b0;
    xfer(8, 0, 0, 0, 4, 0);
    xfer(3, 0, 0, 0, 1, 1);
    xfer(4, 1, 0, 0, 0, 0);
    xfer(4, 1, 1, 1, 2, 0);
    reg_port;
    finish_test;
  end
endmodule // fifo_dma_request_port_tb_top
